//--- logic/tcdist_pkg.sv
// Constants, register layout and carrier types of the bonded transmit clock unit.
package tcdist_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the register bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] TCD_CTRL_OFS = 8'h00;
    localparam logic [7:0] TCD_LANE_MAP_OFS = 8'h04;
    localparam logic [7:0] TCD_STATUS_OFS = 8'h08;
    localparam logic [7:0] TCD_FREQ_PAR_OFS = 8'h0C;
    localparam logic [7:0] TCD_FREQ_FAB_OFS = 8'h10;

    // ------------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [31:0] TCD_CTRL_RST = 32'h0000_0510;
    localparam logic [31:0] TCD_CTRL_WMASK = 32'h0000_0F7F;
    localparam logic [23:0] TCD_LANE_MAP_RST = 24'hFAC688;

    // ------------------------------------------------------------------
    // Bonding geometry
    // ------------------------------------------------------------------
    localparam int TCD_CH_PER_BLOCK = 4;
    localparam int TCD_NUM_CH = 8;
    localparam int TCD_LANE_W = 3;
    localparam logic [7:0] TCD_X4_MASK = 8'h0F;
    localparam logic [7:0] TCD_X8_MASK = 8'hFF;

    // ------------------------------------------------------------------
    // Fixed-rate clock figures in kHz
    // ------------------------------------------------------------------
    localparam logic [31:0] TCD_PCIE_G1_PAR_KHZ = 32'h0003_D090;
    localparam logic [31:0] TCD_PCIE_G2_PAR_KHZ = 32'h0007_A120;
    localparam logic [31:0] TCD_XAUI_PAR_KHZ = 32'h0004_C4B4;

    // ------------------------------------------------------------------
    // Functional modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCD_PCIE_G1,
        TCD_PCIE_G2,
        TCD_XAUI,
        TCD_BASIC
    } tcdist_mode_type;

    // Control register layout.
    typedef struct packed {
        logic [19:0] rsvd_hi;
        logic [3:0] ratio;
        logic rsvd_lo;
        logic hard_ip;
        logic pll_sel;
        logic bsr;
        logic x8;
        tcdist_mode_type mode;
        logic run;
    } tcdist_ctrl_type;

    // Clock and pointer bundle delivered to one bonded channel.
    typedef struct packed {
        logic ser_en;
        logic par_en;
        logic enc_en;
        logic bsr_rd_en;
        logic bsr_wr_en;
        logic fifo_wr_en;
        logic fifo_rd_en;
        logic [2:0] wr_ptr;
        logic [2:0] rd_ptr;
    } tcdist_chan_type;

endpackage

//--- logic/tcdist_pulse_div.sv
// Enable-pulse divider: one output pulse for every ratio input pulses.
module tcdist_pulse_div #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [W-1:0] ratio,
    output logic tick_out
);

    logic [W-1:0] count_r;
    logic [W-1:0] last;

    // A ratio of zero behaves as one, so the output never stalls.
    assign last = (ratio == '0) ? '0 : ratio - W'(1);

    // ------------------------------------------------------------------
    // Counter and registered output pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= '0;
            tick_out <= 1'b0;
        end
        else if (clear)
        begin
            count_r <= '0;
            tick_out <= 1'b0;
        end
        else if (tick_in)
        begin
            if (count_r >= last)
            begin
                count_r <= '0;
                tick_out <= 1'b1;
            end
            else
            begin
                count_r <= count_r + W'(1);
                tick_out <= 1'b0;
            end
        end
        else
        begin
            tick_out <= 1'b0;
        end
    end

endmodule

//--- logic/tcdist_top.sv
// Bonded transmit clock distribution for x4 and x8 channel groups.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
module tcdist_top
    import tcdist_pkg::*;
#(
    parameter int NUM_BLOCKS = 2,
    parameter int PTR_W = 3,
    parameter int RD_LAG = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pll0_tick,
    input wire logic pll1_tick,
    output tcdist_chan_type [TCD_NUM_CH-1:0] chan_clk,
    output logic coreclk_en,
    output logic rx_bond_en,
    output logic bond_active
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [23:0] lane_map_r;
    logic [31:0] hrdata_r;
    logic dp_valid_r;
    logic dp_write_r;
    logic dp_in_r;
    logic [7:0] dp_addr_r;
    logic rd_wait_r;
    logic ahb_take;
    logic wr_commit;
    tcdist_ctrl_type ctrl;
    logic [7:0] act_mask;
    logic [TCD_NUM_CH-1:0] lane_bad;
    logic err_mode;
    logic err_blocks;
    logic err_lane;
    logic err_rate;
    logic active;
    logic clear;
    logic src_tick;
    logic par_tick;
    logic half_r;
    logic fab_tick;
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W-1:0] lag_r;
    logic rd_go;
    logic [31:0] par_khz;
    logic [31:0] fab_khz;
    logic [31:0] status;
    logic [31:0] rd_mux;
    logic active_r;
    logic rx_bond_r;

    assign ctrl = tcdist_ctrl_type'(ctrl_r);

    // ------------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------------

    // An address phase is accepted on a selected NONSEQ or SEQ transfer.
    assign ahb_take = hsel & htrans[1] & hready;

    // Writes complete with no wait; reads take one wait cycle.
    assign wr_commit = dp_valid_r & dp_write_r;
    assign hreadyout = ~rd_wait_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Address phase capture for the following data phase.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_in_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            dp_valid_r <= ahb_take;
            dp_write_r <= hwrite;
            dp_in_r <= (haddr[31:8] == 24'h000000);
            dp_addr_r <= haddr[7:0];
        end
    end

    // Read wait state and read data register.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_wait_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end
        else if (rd_wait_r)
        begin
            rd_wait_r <= 1'b0;
            hrdata_r <= rd_mux;
        end
        else
        begin
            rd_wait_r <= ahb_take & ~hwrite;
        end
    end

    // Software-written control and lane placement registers.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= TCD_CTRL_RST;
            lane_map_r <= TCD_LANE_MAP_RST;
        end
        else if (wr_commit && dp_in_r)
        begin
            if (dp_addr_r == TCD_CTRL_OFS)
            begin
                ctrl_r <= hwdata & TCD_CTRL_WMASK;
            end
            if (dp_addr_r == TCD_LANE_MAP_OFS)
            begin
                lane_map_r <= hwdata[23:0];
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (dp_in_r)
        begin
            unique case (dp_addr_r)
                TCD_CTRL_OFS: rd_mux = ctrl_r;
                TCD_LANE_MAP_OFS: rd_mux = {8'h00, lane_map_r};
                TCD_STATUS_OFS: rd_mux = status;
                TCD_FREQ_PAR_OFS: rd_mux = par_khz;
                TCD_FREQ_FAB_OFS: rd_mux = fab_khz;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration checks
    // ------------------------------------------------------------------

    // Bonded channel set: one block for x4, master plus slave for x8.
    assign act_mask = ctrl.x8 ? TCD_X8_MASK : TCD_X4_MASK;

    // Wide bonding is legal only in PCIe and Basic modes.
    assign err_mode = ctrl.x8 & (ctrl.mode == TCD_XAUI);

    // Wide bonding needs a second block on the same side.
    assign err_blocks = ctrl.x8 & (NUM_BLOCKS < 2);

    // Every bonded logical lane must land on the same-numbered channel.
    genvar g;
    generate
        for (g = 0; g < TCD_NUM_CH; g++)
        begin : g_lane
            assign lane_bad[g] = act_mask[g]
                & (lane_map_r[g*TCD_LANE_W +: TCD_LANE_W]
                   != TCD_LANE_W'(g));
        end
    endgenerate
    assign err_lane = |lane_bad;

    // Without the byte serializer only Gen1 (with the hard block, or x8)
    // and Basic reach the fabric at the full parallel rate.
    assign err_rate = ~ctrl.bsr
        & ((ctrl.mode == TCD_PCIE_G2) | (ctrl.mode == TCD_XAUI)
           | ((ctrl.mode == TCD_PCIE_G1) & ~ctrl.hard_ip
              & ~ctrl.x8));

    // Distribution runs only with a clean configuration.
    assign active = ctrl.run & ~(err_mode | err_blocks | err_lane | err_rate);

    // Divider, halver and pointers are all held cleared together.
    assign clear = ~active;

    // ------------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------------

    // Half-rate clock from the selected synthesizer PLL.
    assign src_tick = active
        & (ctrl.pll_sel ? pll1_tick : pll0_tick);

    // Shared divider in the primary clock unit makes the parallel clock.
    tcdist_pulse_div #(
        .W(4)
    ) u_primary_clock_unit_div (
        .clock(clock),
        .rst_n(rst_n),
        .clear(clear),
        .tick_in(src_tick),
        .ratio(ctrl.ratio),
        .tick_out(par_tick)
    );

    // Divide-by-two stage; its phase restarts with the pointers.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_r <= 1'b0;
        end
        else if (clear)
        begin
            half_r <= 1'b0;
        end
        else if (par_tick)
        begin
            half_r <= ~half_r;
        end
    end

    // Fabric interface clock: halved with byte serializer, else direct.
    assign fab_tick = ctrl.bsr
        ? (par_tick & half_r)
        : par_tick;

    // ------------------------------------------------------------------
    // Shared phase-compensation FIFO pointers
    // ------------------------------------------------------------------

    // Write pointer advances on each fabric clock.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
        end
        else if (clear)
        begin
            wr_ptr_r <= '0;
        end
        else if (fab_tick)
        begin
            wr_ptr_r <= wr_ptr_r + PTR_W'(1);
        end
    end

    // Reading starts a fixed number of fabric clocks after writing.
    assign rd_go = fab_tick & (lag_r == PTR_W'(RD_LAG));

    // Start-up lag counter and read pointer.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lag_r <= '0;
            rd_ptr_r <= '0;
        end
        else if (clear)
        begin
            lag_r <= '0;
            rd_ptr_r <= '0;
        end
        else if (fab_tick)
        begin
            if (lag_r != PTR_W'(RD_LAG))
            begin
                lag_r <= lag_r + PTR_W'(1);
            end
            if (rd_go)
            begin
                rd_ptr_r <= rd_ptr_r + PTR_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-channel distribution
    // ------------------------------------------------------------------

    // Every bonded channel receives the same registered bundle, so the
    // only skew left is routing; unbonded channels stay quiet.
    generate
        for (g = 0; g < TCD_NUM_CH; g++)
        begin : g_chan
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    chan_clk[g] <= '0;
                end
                else if (act_mask[g] && active)
                begin
                    chan_clk[g].ser_en <= src_tick;
                    chan_clk[g].par_en <= par_tick;
                    chan_clk[g].enc_en <= par_tick;
                    chan_clk[g].bsr_rd_en <= par_tick & ctrl.bsr;
                    chan_clk[g].bsr_wr_en <= fab_tick & ctrl.bsr;
                    chan_clk[g].fifo_wr_en <= fab_tick;
                    chan_clk[g].fifo_rd_en <= rd_go;
                    chan_clk[g].wr_ptr <= 3'(wr_ptr_r);
                    chan_clk[g].rd_ptr <= 3'(rd_ptr_r);
                end
                else
                begin
                    chan_clk[g] <= '0;
                end
            end
        end
    endgenerate

    // Exported fabric clock enable, receive bonding and run state.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coreclk_en <= 1'b0;
            rx_bond_r <= 1'b0;
            active_r <= 1'b0;
        end
        else
        begin
            // Gated like the channel bundle so a stop never leaves a
            // stray fabric tick behind the last channel tick.
            coreclk_en <= fab_tick & active;
            rx_bond_r <= active & (ctrl.mode != TCD_BASIC);
            active_r <= active;
        end
    end

    assign rx_bond_en = rx_bond_r;
    assign bond_active = active_r;

    // ------------------------------------------------------------------
    // Rate report and status
    // ------------------------------------------------------------------

    // Nominal parallel and fabric rates; Basic runs at a variable rate
    // and reports zero; the fabric rate also reads zero when the rate check fails.
    always_comb
    begin
        par_khz = 32'h0000_0000;
        unique case (ctrl.mode)
            TCD_PCIE_G1: par_khz = TCD_PCIE_G1_PAR_KHZ;
            TCD_PCIE_G2: par_khz = TCD_PCIE_G2_PAR_KHZ;
            TCD_XAUI: par_khz = TCD_XAUI_PAR_KHZ;
            TCD_BASIC: par_khz = 32'h0000_0000;
        endcase
        if (err_rate)
        begin
            fab_khz = 32'h0000_0000;
        end
        else if (ctrl.bsr)
        begin
            fab_khz = {1'b0, par_khz[31:1]};
        end
        else
        begin
            fab_khz = par_khz;
        end
    end

    // Status word showing live state of the distribution.
    assign status = {
        6'h00,
        5'(rd_ptr_r),
        5'(wr_ptr_r),
        act_mask,
        1'b0,
        half_r,
        rx_bond_r,
        err_rate,
        err_lane,
        err_blocks,
        err_mode,
        active_r
    };

    // Transfer size and data-phase width are fixed at one word.
    logic unused_ok;
    assign unused_ok = ^hsize;

endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the bonded transmit clock unit.
module tb_top
    import tcdist_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic pll0_tick = 1'h0;
    logic pll1_tick = 1'h0;
    logic [2:0] ph = 3'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    tcdist_chan_type [TCD_NUM_CH-1:0] chan_clk;
    logic coreclk_en;
    logic rx_bond_en;
    logic bond_active;
    logic [31:0] fab_ticks;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    tcdist_top DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .pll0_tick(pll0_tick),
        .pll1_tick(pll1_tick), .chan_clk(chan_clk),
        .coreclk_en(coreclk_en), .rx_bond_en(rx_bond_en),
        .bond_active(bond_active));
    tcdist_fabric_model FAB (.clock(clock), .rst_n(rst_n),
        .coreclk_en(coreclk_en), .ticks(fab_ticks));

    always #5 clock = ~clock;

    // Half-rate ticks: primary every 2 cycles, secondary every 3.
    always @(posedge clock)
    begin
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        pll0_tick <= ~ph[0];
        pll1_tick <= (ph == 3'h0) || (ph == 3'h3);
    end

    // A hung run is cut short and reported.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            err_total++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One single bus transfer; hready and read data taken at rising edges.
    task automatic bus_xfer(input logic [7:0] a, input logic wr,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do
        begin
            @(posedge clock);
        end while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(posedge clock);
        end while (hready !== 1'h1);
        q = hrdata;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(a, 1'h1, d, q);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_regs();
        logic [31:0] q;
        chk({31'h0, bond_active | coreclk_en | (|chan_clk)}, 32'h0);
        bus_xfer(TCD_CTRL_OFS, 1'h0, 32'h0, q);
        chk(q, TCD_CTRL_RST);
        bus_xfer(TCD_LANE_MAP_OFS, 1'h0, 32'h0, q);
        chk(q, {8'h0, TCD_LANE_MAP_RST});
        bus_wr(8'h40, 32'h1234_5678);
        bus_xfer(8'h40, 1'h0, 32'h0, q);
        chk(q, 32'h0);
        bus_wr(TCD_CTRL_OFS, 32'hFFFF_F0FE);
        bus_xfer(TCD_CTRL_OFS, 1'h0, 32'h0, q);
        chk(q, 32'hFFFF_F0FE & TCD_CTRL_WMASK);
    endtask

    // Counts the enables over a window that spans whole tick periods.
    task automatic t_rates(input logic [31:0] ctrl, ser, par, fab,
        input logic [31:0] fpar, ffab, input logic rx, input logic [7:0] mk);
        logic [31:0] q;
        logic [31:0] s;
        logic [31:0] p;
        logic [31:0] f0;
        logic [31:0] b;
        logic r;
        bus_wr(TCD_CTRL_OFS, ctrl);
        repeat (30) @(posedge clock);
        s = 32'h0;
        p = 32'h0;
        b = 32'h0;
        @(negedge clock);
        f0 = fab_ticks;
        repeat (120)
        begin
            @(negedge clock);
            s += chan_clk[0].ser_en;
            p += chan_clk[0].par_en;
            b += chan_clk[3].bsr_wr_en;
            r = rx_bond_en;
        end
        chk(b, ctrl[4] ? fab : 32'h0);
        chk(s, ser);
        chk(p, par);
        chk(fab_ticks - f0, fab);
        chk({31'h0, r}, {31'h0, rx});
        @(posedge clock);
        bus_xfer(TCD_STATUS_OFS, 1'h0, 32'h0, q);
        chk(q & 32'hFF1F, {16'h0, mk, 8'h01});
        bus_xfer(TCD_FREQ_PAR_OFS, 1'h0, 32'h0, q);
        chk(q, fpar);
        bus_xfer(TCD_FREQ_FAB_OFS, 1'h0, 32'h0, q);
        chk(q, ffab);
    endtask

    task automatic t_errors();
        logic [31:0] q;
        bus_wr(TCD_CTRL_OFS, 32'h0000_011D);
        bus_xfer(TCD_STATUS_OFS, 1'h0, 32'h0, q);
        chk(q & 32'h1F, 32'h02);
        bus_wr(TCD_CTRL_OFS, 32'h0000_0101);
        bus_xfer(TCD_STATUS_OFS, 1'h0, 32'h0, q);
        chk(q & 32'h1F, 32'h10);
        bus_wr(TCD_CTRL_OFS, 32'h0000_0141);
        bus_wr(TCD_LANE_MAP_OFS, 32'h00FA_C681);
        bus_xfer(TCD_STATUS_OFS, 1'h0, 32'h0, q);
        chk(q & 32'h1F, 32'h08);
        @(negedge clock);
        chk({31'h0, coreclk_en | (|chan_clk)}, 32'h0);
        @(posedge clock);
        bus_wr(TCD_LANE_MAP_OFS, {8'h0, TCD_LANE_MAP_RST});
    endtask

    // The first fifo read lands on the third fabric tick after start.
    task automatic t_rd_lag();
        logic [31:0] n;
        logic rd;
        int i;
        n = 32'h0;
        rd = 1'h0;
        bus_wr(TCD_CTRL_OFS, 32'h0000_0140);
        bus_wr(TCD_CTRL_OFS, 32'h0000_0141);
        for (i = 0; i < 40 && rd !== 1'h1; i++)
        begin
            @(negedge clock);
            n += coreclk_en;
            rd = chan_clk[0].fifo_rd_en;
        end
        chk(n, 32'h3);
        chk({31'h0, rd}, 32'h1);
        @(posedge clock);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        t_reset_regs();
        t_rates(32'h141, 32'h3C, 32'h3C, 32'h3C, TCD_PCIE_G1_PAR_KHZ,
            TCD_PCIE_G1_PAR_KHZ, 1'h1, TCD_X4_MASK);
        t_rates(32'h231, 32'h28, 32'h14, 32'h0A, TCD_PCIE_G1_PAR_KHZ,
            32'h0001_E848, 1'h1, TCD_X4_MASK);
        t_rates(32'h313, 32'h3C, 32'h14, 32'h0A, TCD_PCIE_G2_PAR_KHZ,
            TCD_PCIE_G1_PAR_KHZ, 1'h1, TCD_X4_MASK);
        t_rates(32'h115, 32'h3C, 32'h3C, 32'h1E, TCD_XAUI_PAR_KHZ,
            32'h0002_625A, 1'h1, TCD_X4_MASK);
        t_rates(32'h12F, 32'h28, 32'h28, 32'h28, 32'h0, 32'h0,
            1'h0, TCD_X8_MASK);
        t_errors();
        t_rd_lag();
        results();
    end
endmodule

//--- testbench/tcdist_fabric_model.sv
// Fabric-side transmit logic model counting its bonded clock ticks.
module tcdist_fabric_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic coreclk_en,
    output logic [31:0] ticks
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Transmit word launch
    // ------------------------------------------------------------------
    // Fabric logic launches one transmit word per bonded clock tick.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ticks <= 32'h0;
        else if (coreclk_en)
            ticks <= ticks + 32'h1;
    end
endmodule

//--- testbench/tcdist_top_properties.sv
// Concurrent checks on the ports of the bonded transmit clock unit.
module tcdist_top_properties
    import tcdist_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pll0_tick,
    input wire logic pll1_tick,
    input wire tcdist_chan_type [TCD_NUM_CH-1:0] chan_clk,
    input wire logic coreclk_en,
    input wire logic rx_bond_en,
    input wire logic bond_active
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // A read taken on the bus, and one fabric tick while bonded.
    sequence s_rd_req;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_fab_tick;
        bond_active && chan_clk[0].fifo_wr_en;
    endsequence

    a_okay_resp: assert property (!hresp)
        else $error("bus response not okay");
    a_read_wait: assert property (s_rd_req |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_ser_src: assert property (chan_clk[0].ser_en |->
        $past(pll0_tick || pll1_tick)) else $error("serial tick unsourced");
    a_par_after_ser: assert property (chan_clk[0].par_en |->
        $past(chan_clk[0].ser_en)) else $error("parallel tick unsourced");
    a_lanes_equal: assert property (
        chan_clk[3:1] == {3{chan_clk[0]}}) else $error("x4 lanes differ");
    a_upper_equal: assert property (chan_clk[7:4] == '0 ||
        chan_clk[7:4] == {4{chan_clk[0]}}) else $error("x8 lanes differ");
    a_enc_par: assert property (
        chan_clk[0].enc_en == chan_clk[0].par_en)
        else $error("encoder tick differs");
    a_fab_fifo: assert property (coreclk_en |->
        chan_clk[0].par_en && chan_clk[0].fifo_wr_en)
        else $error("fabric tick without parallel tick");
    a_fifo_fab: assert property (
        chan_clk[0].fifo_wr_en == coreclk_en)
        else $error("fifo write apart from fabric tick");
    a_rd_on_tick: assert property (chan_clk[0].fifo_rd_en |->
        chan_clk[0].fifo_wr_en) else $error("fifo read off tick");
    a_wr_step: assert property (s_fab_tick ##1 bond_active |->
        chan_clk[0].wr_ptr == $past(chan_clk[0].wr_ptr) + 3'h1)
        else $error("write pointer did not step");
    a_idle_quiet: assert property (!bond_active &&
        $past(!bond_active) |-> chan_clk == '0 && !coreclk_en)
        else $error("outputs active while idle");
    a_rx_bond: assert property (rx_bond_en |-> bond_active)
        else $error("receive bonding while idle");
endmodule

bind tcdist_top tcdist_top_properties u_props (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .pll0_tick(pll0_tick), .pll1_tick(pll1_tick),
    .chan_clk(chan_clk), .coreclk_en(coreclk_en),
    .rx_bond_en(rx_bond_en), .bond_active(bond_active)
);
